// ===== design/qtc_defs.svh
/*
  Constants of the quad counter/timer group: register offsets, field
  positions, reset value and divider counts.
  Assumes it is included by bare name; the guard allows repeated inclusion.
*/
`ifndef QTC_DEFS_SVH
`define QTC_DEFS_SVH
// ----------------------------------------
// bus widths and reset byte
// ----------------------------------------
`define QTC_ADDR_W     5
`define QTC_DATA_W     8
`define QTC_RST_BYTE   8'h00
// ----------------------------------------
// register offsets
// ----------------------------------------
`define QTC_REG_MODE   5'h00
`define QTC_REG_CLK    5'h01
`define QTC_REG_RUN    5'h02
`define QTC_REG_STATUS 5'h03
`define QTC_REG_MASK   5'h04
`define QTC_REG_CNT0   5'h05
`define QTC_REG_CNT7   5'h0c
`define QTC_REG_RLD0   5'h0d
`define QTC_REG_RLD3   5'h10
// ----------------------------------------
// field positions
// ----------------------------------------
`define QTC_F_MODE_A   0
`define QTC_F_MODE_B   2
`define QTC_F_CNT_A    4
`define QTC_F_CNT_B    5
`define QTC_F_GATE_A   6
`define QTC_F_GATE_B   7
`define QTC_F_PRESCALE 0
`define QTC_F_FAST_A   2
`define QTC_F_FAST_B   3
`define QTC_F_SRC_C    4
`define QTC_F_SRC_D    6
`define QTC_F_SPLIT_C  4
`define QTC_F_SPLIT_D  5
`define QTC_ST_A       0
`define QTC_ST_B       1
`define QTC_ST_CLO     2
`define QTC_ST_DLO     4
`define QTC_ST_WAKE    6
// ----------------------------------------
// divider terminal counts (divide by 12, 4, 48, 8)
// ----------------------------------------
`define QTC_DIV12_LAST 4'hb
`define QTC_DIV4_LAST  2'h3
`define QTC_DIV48_LAST 6'h2f
`define QTC_EXT8_LAST  3'h7
`endif

// ===== design/qtc_pkg.sv
/*
  Types of the quad counter/timer group.
  Assumes qtc_defs.svh is on the include path.
*/
`include "qtc_defs.svh"
package qtc_pkg;
  typedef logic [`QTC_ADDR_W-1:0] qtc_addr_t;
  typedef logic [`QTC_DATA_W-1:0] qtc_byte_t;
  // operating modes of timers a and b
  typedef enum logic [1:0] {
    QTC_MODE13    = 2'h0,
    QTC_MODE16    = 2'h1,
    QTC_MODE8R    = 2'h2,
    QTC_MODESPLIT = 2'h3
  } qtc_mode_e;
  // clock sources of timers c and d
  typedef enum logic [1:0] {
    QTC_SRC_DIV12 = 2'h0,
    QTC_SRC_SYS   = 2'h1,
    QTC_SRC_EXT8  = 2'h2
  } qtc_src_e;
  typedef struct packed {
    logic s1, s2, s3, lvl, fall, rise;
  } qtc_sync_s;
  typedef struct packed {
    logic [3:0] c12;
    logic [1:0] c4;
    logic [5:0] c48;
    logic [2:0] e8;
    logic       en12, en4, en48, ext8;
  } qtc_pre_s;
  typedef struct packed {
    logic [7:0]       mode, clk, run, status, mask, rdata;
    logic [3:0][15:0] cnt;
    logic [1:0][15:0] rld;
    logic [3:0]       ovf;
  } qtc_top_s;
endpackage : qtc_pkg

// ===== design/qtc_sync.sv
/*
  Pin synchroniser with filtered falling and rising event pulses.
  Assumes the pin is asynchronous to clock.
*/
`timescale 1ns/1ps
module qtc_sync (
  input  logic clock,
  input  logic sys_rst,
  input  logic pin,
  output logic lvl,
  output logic fall,
  output logic rise
);
  import qtc_pkg::*;
  qtc_sync_s s, n;
  // ----------------------------------------
  // three stages; a level counts once stages two and three agree
  // ----------------------------------------
  always_comb begin
    n      = s;
    n.s1   = pin;
    n.s2   = s.s1;
    n.s3   = s.s2;
    n.fall = 1'b0;
    n.rise = 1'b0;
    if (s.s2 == s.s3 && s.s3 != s.lvl) begin
      n.lvl  = s.s3;
      n.fall = ~s.s3;
      n.rise = s.s3;
    end
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) s <= '0;
    else s <= n;
  end
  assign lvl  = s.lvl;
  assign fall = s.fall;
  assign rise = s.rise;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_fall_follows_level: assert property (fall |-> !lvl && $past(lvl))
    else $error("fall pulse without a high to low level change");
  a_fall_one_cycle: assert property (fall |=> !fall)
    else $error("fall pulse longer than one cycle");
endmodule : qtc_sync

// ===== design/qtc_prescale.sv
/*
  Divided clock sources as one-cycle enables of the system clock.
  Assumes ext_rise is a synchronised one-cycle pulse.
*/
`timescale 1ns/1ps
`include "qtc_defs.svh"
module qtc_prescale (
  input  logic clock,
  input  logic sys_rst,
  input  logic ext_rise,
  output logic en12,
  output logic en4,
  output logic en48,
  output logic ext8
);
  import qtc_pkg::*;
  qtc_pre_s s, n;
  // ----------------------------------------
  // free running dividers and an oscillator edge counter, each ends in a one-cycle enable
  // ----------------------------------------
  always_comb begin
    n      = s;
    n.en12 = s.c12 == `QTC_DIV12_LAST;
    n.c12  = n.en12 ? 4'h0 : s.c12 + 4'h1;
    n.en4  = s.c4 == `QTC_DIV4_LAST;
    n.c4   = s.c4 + 2'h1;
    n.en48 = s.c48 == `QTC_DIV48_LAST;
    n.c48  = n.en48 ? 6'h00 : s.c48 + 6'h01;
    n.ext8 = ext_rise && s.e8 == `QTC_EXT8_LAST;
    if (ext_rise) n.e8 = s.e8 + 3'h1;
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) s <= '0;
    else s <= n;
  end
  assign en12 = s.en12;
  assign en4  = s.en4;
  assign en48 = s.en48;
  assign ext8 = s.ext8;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_div4_period: assert property (en4 |=> !en4 [*3] ##1 en4)
    else $error("divide by 4 enable off period");
  a_div12_period: assert property (en12 |=> !en12 [*8] ##1 !en12 [*3] ##1 en12)
    else $error("divide by 12 enable off period");
  a_div48_period: assert property (en48 |-> ##48 en48)
    else $error("divide by 48 enable off period");
endmodule : qtc_prescale

// ===== design/qtc_top.sv
/*
  Quad counter/timer group: timers a and b with 13-bit, 16-bit and
  8-bit reload modes, split mode on a, timers c and d with 16-bit or split
  8-bit reload, sticky overflow status, mask, interrupt and wake.
  Assumes a 125 MHz clock, asynchronous pins and a byte register port
  whose read data appear one cycle after the read strobe.
*/
// Local design decisions: the address-and-strobe port and the address map.
// Notes on behaviour
// - four 16-bit timers: two classic counter/timers, two reload timers
// - timers a and b offer 13-bit, 16-bit and 8-bit reload modes, timer a also split mode
// - split mode exists on timer a only, never on timer b
// - timers c and d run as 16-bit reload or two 8-bit reload halves
// - timer d runs from the oscillator in suspend and can wake
// - timers a and b pick among five sources via fast bit and prescale
// - each of a and b uses prescaled clock or full system clock
// - c and d clock from system clock, clock over 12, oscillator over 8
// - in counter operation a falling pin edge adds one
// - pin events up to a quarter of system clock are counted
// - timers measure time, count events and raise periodic interrupts
// - prescale: 00 over 12, 01 over 4, 10 over 48, 11 oscillator over 8
// - 13-bit rollover from 1fff to zero sets the overflow flag
// - a running timer counts only with gate off or gate input high, except the split high byte of a, which ignores both gates
// - 8-bit reload: low byte wraps, sets flag, reloads from high byte
`timescale 1ns/1ps
`include "qtc_defs.svh"
module qtc_top (
  input  logic              clock,
  input  logic              sys_rst,
  input  qtc_pkg::qtc_addr_t reg_addr,
  input  qtc_pkg::qtc_byte_t reg_wdata,
  input  logic              reg_wr,
  input  logic              reg_rd,
  output qtc_pkg::qtc_byte_t reg_rdata,
  input  logic              timer_a_count_pin,
  input  logic              timer_b_count_pin,
  input  logic              external_gate_input,
  input  logic              timer_b_gate_input,
  input  logic              ext_osc_pin,
  input  logic              suspend,
  output logic [3:0]        timer_ovf,
  output logic              irq,
  output logic              wake_request
);
  import qtc_pkg::*;

  qtc_top_s   s, n;
  logic [4:0] pins, pin_lvl, pin_fall, pin_rise;
  logic       en12, en4, en48, ext8;
  logic       pre_tick, tick_a, tick_b, tick_ah;
  logic       go_a, go_b, go_ah;
  logic [1:0] go_cd, split_cd, tick_cd;
  logic [1:0] mode_a, mode_b;
  logic [7:0] set, clr;
  logic [16:0] ra, rb;
  logic [17:0] rc;
  logic [4:0] cidx, ridx;

  // ----------------------------------------
  // step functions
  // ----------------------------------------
  // one count of timer a or b; result is {overflow, next value}
  function automatic logic [16:0] step_ab(input logic [1:0] m,
                                          input logic [15:0] v);
    logic [12:0] v13;
    v13 = {v[15:8], v[4:0]} + 13'h0001;
    case (m)
      QTC_MODE13: step_ab = {v13 == 13'h0000, v13[12:5], v[7:5], v13[4:0]};
      QTC_MODE16: step_ab = {v == 16'hffff, v + 16'h0001};
      QTC_MODE8R: step_ab = {v[7:0] == 8'hff, v[15:8],
                             (v[7:0] == 8'hff) ? v[15:8] : v[7:0] + 8'h01};
      default:    step_ab = {v[7:0] == 8'hff, v[15:8], v[7:0] + 8'h01};
    endcase
  endfunction : step_ab

  // one count of timer c or d; result is {high ovf, low ovf, next value}
  function automatic logic [17:0] step_cd(input logic sp,
                                          input logic [15:0] v,
                                          input logic [15:0] r);
    logic lo_w, hi_w;
    lo_w = v[7:0] == 8'hff;
    hi_w = v[15:8] == 8'hff;
    if (!sp) begin
      step_cd = {1'b0, v == 16'hffff, (v == 16'hffff) ? r : v + 16'h0001};
    end else begin
      step_cd = {hi_w, lo_w, hi_w ? r[15:8] : v[15:8] + 8'h01,
                 lo_w ? r[7:0] : v[7:0] + 8'h01};
    end
  endfunction : step_cd

  // clock source decode of timer c or d
  function automatic logic src_tick(input logic [1:0] sel,
                                    input logic e12, input logic e8);
    case (sel)
      QTC_SRC_SYS:   src_tick = 1'b1;
      QTC_SRC_DIV12: src_tick = e12;
      QTC_SRC_EXT8:  src_tick = e8;
      default:       src_tick = 1'b0;
    endcase
  endfunction : src_tick

  // ----------------------------------------
  // pin synchronisers and dividers
  // ----------------------------------------
  // pins: 0 count a, 1 count b, 2 gate a, 3 gate b, 4 oscillator
  assign pins = {ext_osc_pin, timer_b_gate_input, external_gate_input,
                 timer_b_count_pin, timer_a_count_pin};
  for (genvar g = 0; g < 5; g++) begin : g_sync
    qtc_sync qtc_sync_i (
      .clock   (clock),
      .sys_rst (sys_rst),
      .pin     (pins[g]),
      .lvl     (pin_lvl[g]),
      .fall    (pin_fall[g]),
      .rise    (pin_rise[g])
    );
  end

  qtc_prescale qtc_prescale_i (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .ext_rise (pin_rise[4]),
    .en12     (en12),
    .en4      (en4),
    .en48     (en48),
    .ext8     (ext8)
  );

  // ----------------------------------------
  // count enables
  // ----------------------------------------
  assign mode_a = s.mode[`QTC_F_MODE_A +: 2];
  assign mode_b = s.mode[`QTC_F_MODE_B +: 2];
  // shared prescaled source
  always_comb begin
    case (s.clk[`QTC_F_PRESCALE +: 2])
      2'h0:    pre_tick = en12;
      2'h1:    pre_tick = en4;
      2'h2:    pre_tick = en48;
      default: pre_tick = ext8;
    endcase
  end
  // timer or counter source of a and b, six choices in all
  assign tick_ah = s.clk[`QTC_F_FAST_A] | pre_tick;
  assign tick_a  = s.mode[`QTC_F_CNT_A] ? pin_fall[0] : tick_ah;
  assign tick_b  = s.mode[`QTC_F_CNT_B] ? pin_fall[1]
                 : (s.clk[`QTC_F_FAST_B] | pre_tick);
  // run bit and gate
  assign go_a  = s.run[0] & (~s.mode[`QTC_F_GATE_A] | pin_lvl[2])
               & tick_a & ~suspend;
  assign go_b  = s.run[1] & (~s.mode[`QTC_F_GATE_B] | pin_lvl[3])
               & tick_b & ~suspend & (mode_b != QTC_MODESPLIT);
  assign go_ah = (mode_a == QTC_MODESPLIT) & s.run[1] & tick_ah
               & ~suspend;
  // timers c and d; d falls back to the oscillator in suspend
  assign split_cd = {s.run[`QTC_F_SPLIT_D], s.run[`QTC_F_SPLIT_C]};
  assign tick_cd[0] = ~suspend & src_tick(s.clk[`QTC_F_SRC_C +: 2], en12, ext8);
  assign tick_cd[1] = suspend ? ext8
                    : src_tick(s.clk[`QTC_F_SRC_D +: 2], en12, ext8);
  assign go_cd = s.run[3:2] & tick_cd;

  assign ra   = step_ab(mode_a, s.cnt[0]);
  assign rb   = step_ab(mode_b, s.cnt[1]);
  assign cidx = reg_addr - `QTC_REG_CNT0;
  assign ridx = reg_addr - `QTC_REG_RLD0;

  // ----------------------------------------
  // next state: counting, flags, register access
  // ----------------------------------------
  always_comb begin
    n     = s;
    set   = 8'h00;
    clr   = 8'h00;
    rc    = 18'h00000;
    n.rdata = `QTC_RST_BYTE;
    if (go_a) begin
      n.cnt[0] = ra[15:0];
      set[`QTC_ST_A] = ra[16];
    end
    if (go_ah) begin // split high byte borrows timer b's run and flag
      n.cnt[0][15:8] = s.cnt[0][15:8] + 8'h01;
      set[`QTC_ST_B] = s.cnt[0][15:8] == 8'hff;
    end
    if (go_b) begin
      n.cnt[1] = rb[15:0];
      if (mode_a != QTC_MODESPLIT) set[`QTC_ST_B] = rb[16];
    end
    for (int i = 0; i < 2; i++) begin
      if (go_cd[i]) begin
        rc = step_cd(split_cd[i], s.cnt[i+2], s.rld[i]);
        n.cnt[i+2] = rc[15:0];
        set[`QTC_ST_CLO + 2*i]     = rc[16];
        set[`QTC_ST_CLO + 2*i + 1] = rc[17];
      end
    end
    set[`QTC_ST_WAKE] = suspend & (set[4] | set[5]);
    n.ovf = {set[5] | set[4], set[3] | set[2], set[1], set[0]};
    // writes land after counting so software loads win
    if (reg_wr) begin
      case (reg_addr)
        `QTC_REG_MODE:   n.mode = reg_wdata;
        `QTC_REG_CLK:    n.clk  = reg_wdata;
        `QTC_REG_RUN:    n.run  = reg_wdata;
        `QTC_REG_STATUS: clr    = reg_wdata;
        `QTC_REG_MASK:   n.mask = reg_wdata;
        default: begin
          if (reg_addr >= `QTC_REG_CNT0 && reg_addr <= `QTC_REG_CNT7)
            n.cnt[cidx[2:1]][{cidx[0], 3'h0} +: 8] = reg_wdata;
          if (reg_addr >= `QTC_REG_RLD0 && reg_addr <= `QTC_REG_RLD3)
            n.rld[ridx[1]][{ridx[0], 3'h0} +: 8] = reg_wdata;
        end
      endcase
    end
    // a new event beats a clear in the same cycle
    n.status = (s.status & ~clr) | set;
    if (reg_rd) begin
      case (reg_addr)
        `QTC_REG_MODE:   n.rdata = s.mode;
        `QTC_REG_CLK:    n.rdata = s.clk;
        `QTC_REG_RUN:    n.rdata = s.run;
        `QTC_REG_STATUS: n.rdata = s.status;
        `QTC_REG_MASK:   n.rdata = s.mask;
        default: begin
          if (reg_addr >= `QTC_REG_CNT0 && reg_addr <= `QTC_REG_CNT7)
            n.rdata = s.cnt[cidx[2:1]][{cidx[0], 3'h0} +: 8];
          if (reg_addr >= `QTC_REG_RLD0 && reg_addr <= `QTC_REG_RLD3)
            n.rdata = s.rld[ridx[1]][{ridx[0], 3'h0} +: 8];
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) s <= '0;
    else s <= n;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata    = s.rdata;
  assign timer_ovf    = s.ovf;
  assign irq          = |(s.status & s.mask); // level while any unmasked flag
  assign wake_request = s.status[`QTC_ST_WAKE];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_roll_13bit: assert property (go_a && mode_a == QTC_MODE13 && !reg_wr
    && {s.cnt[0][15:8], s.cnt[0][4:0]} == 13'h1fff
    |=> s.status[0] && s.cnt[0][15:8] == 8'h00 && s.cnt[0][4:0] == 5'h00)
    else $error("13-bit rollover did not clear count and set flag");
  a_reload_8bit: assert property (go_a && mode_a == QTC_MODE8R && !reg_wr
    && s.cnt[0][7:0] == 8'hff
    |=> s.cnt[0][7:0] == $past(s.cnt[0][15:8]) && $stable(s.cnt[0][15:8]))
    else $error("8-bit reload wrong");
  a_gate_hold: assert property (s.run[0] && s.mode[`QTC_F_GATE_A]
    && !pin_lvl[2] && mode_a != QTC_MODESPLIT && !reg_wr |=> $stable(s.cnt[0]))
    else $error("timer a counted with gate closed");
  a_count_fall: assert property (s.mode[`QTC_F_CNT_A] && s.run[0]
    && !s.mode[`QTC_F_GATE_A] && !suspend && mode_a == QTC_MODE16
    && pin_fall[0] && !reg_wr |=> s.cnt[0] == $past(s.cnt[0]) + 16'h0001)
    else $error("falling pin edge not counted");
  a_count_idle: assert property (s.mode[`QTC_F_CNT_A] && !pin_fall[0]
    && mode_a != QTC_MODESPLIT && !reg_wr |=> $stable(s.cnt[0]))
    else $error("counter moved without a pin edge");
  a_fast_clock: assert property (!s.mode[`QTC_F_CNT_A] && s.clk[`QTC_F_FAST_A]
    && s.run[0] && !s.mode[`QTC_F_GATE_A] && !suspend && mode_a == QTC_MODE16
    && !reg_wr ##1 !reg_wr |-> s.cnt[0] == $past(s.cnt[0]) + 16'h0001)
    else $error("fast clock did not count every cycle");
  a_no_split_b: assert property (mode_b == QTC_MODESPLIT && !reg_wr
    |=> $stable(s.cnt[1]))
    else $error("timer b moved in split mode");
  a_cd_reload: assert property (go_cd[0] && !split_cd[0] && !reg_wr
    && s.cnt[2] == 16'hffff |=> s.cnt[2] == $past(s.rld[0]) && s.status[2])
    else $error("timer c did not reload");
  a_wake_raise: assert property (suspend && ext8 && s.run[3] && !split_cd[1]
    && s.cnt[3] == 16'hffff |=> wake_request)
    else $error("timer d overflow in suspend did not wake");
  a_irq_raise: assert property (set[0] && s.mask[0] && !reg_wr ##1 !reg_wr
    |-> irq [*2])
    else $error("unmasked overflow did not hold interrupt");

  c_roll_13bit: cover property (set[0] && mode_a == QTC_MODE13);
  c_split_high: cover property (go_cd[0] && split_cd[0] && set[3]);
  c_wake:       cover property (wake_request);
  c_pin_count:  cover property (pin_fall[0] && go_a);
endmodule : qtc_top

// ===== dv/qtc_pin_src.sv
/*
  Pin source model: count events, gate levels and an oscillator pin.
  Assumes the bench calls its tasks and shares the system clock.
*/
`timescale 1ns/1ps
module qtc_pin_src (
  input  logic clock,
  output logic timer_a_count_pin,
  output logic timer_b_count_pin,
  output logic external_gate_input,
  output logic timer_b_gate_input,
  output logic ext_osc_pin
);
  // ----------------------------------------
  // idle levels: count pins high, gates off
  // ----------------------------------------
  initial begin
    timer_a_count_pin   = 1'b1;
    timer_b_count_pin   = 1'b1;
    external_gate_input = 1'b0;
    timer_b_gate_input  = 1'b0;
    ext_osc_pin         = 1'b0;
  end
  // falling events, each level held hold cycles (hold of 2 or more)
  task automatic events(input bit b, input int n, input int hold);
    repeat (n) begin
      @(posedge clock);
      if (b) timer_b_count_pin <= 1'b0;
      else timer_a_count_pin <= 1'b0;
      repeat (hold) @(posedge clock);
      if (b) timer_b_count_pin <= 1'b1;
      else timer_a_count_pin <= 1'b1;
      repeat (hold - 1) @(posedge clock);
    end
  endtask : events
  // oscillator pin, period of four system cycles
  task automatic osc(input int n);
    repeat (n) begin
      @(posedge clock);
      ext_osc_pin <= 1'b1;
      repeat (2) @(posedge clock);
      ext_osc_pin <= 1'b0;
      @(posedge clock);
    end
  endtask : osc
  // gate levels
  task automatic gate(input logic a, input logic b);
    @(posedge clock);
    external_gate_input <= a;
    timer_b_gate_input  <= b;
  endtask : gate
endmodule : qtc_pin_src

// ===== dv/test_qtc_top.sv
/*
  Self-checking bench of the quad counter/timer group.
  Assumes qtc_pkg, qtc_defs.svh and qtc_pin_src are compiled first.
*/
`timescale 1ns/1ps
`include "qtc_defs.svh"
module test_qtc_top;
  import qtc_pkg::*;
  logic       clock = 1'b0;
  logic       sys_rst = 1'b1;
  qtc_addr_t  reg_addr = '0;
  qtc_byte_t  reg_wdata = '0;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       suspend = 1'b0;
  qtc_byte_t  reg_rdata, rv;
  logic       pa, pb, ga, gb, osc;
  logic [3:0] timer_ovf;
  logic       irq, wake_request;
  logic [15:0] v;
  int         bad_count = 0;
  int         compares = 0;
  int         cycles = 0;
  int         dv[3] = '{12, 4, 48};
  qtc_top qtc_top_i (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_a_count_pin(pa), .timer_b_count_pin(pb), .external_gate_input(ga),
    .timer_b_gate_input(gb), .ext_osc_pin(osc), .suspend(suspend),
    .timer_ovf(timer_ovf), .irq(irq), .wake_request(wake_request));
  qtc_pin_src qtc_pin_src_i (.clock(clock), .timer_a_count_pin(pa),
    .timer_b_count_pin(pb), .external_gate_input(ga), .timer_b_gate_input(gb),
    .ext_osc_pin(osc));
  // ----------------------------------------
  // clock, timeout and verdict
  // ----------------------------------------
  always #4 clock = ~clock;
  // cut a hang short
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail("timeout");
      stop_test();
    end
  end
  task automatic stop_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic wr(input qtc_addr_t a, input qtc_byte_t d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input qtc_addr_t a, output qtc_byte_t d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  function automatic qtc_addr_t ca(input int t);
    return `QTC_REG_CNT0 + 5'(t);
  endfunction : ca
  task automatic rd16(input int t, output logic [15:0] r);
    qtc_byte_t l, h;
    rd(ca(2 * t), l);
    rd(ca(2 * t + 1), h);
    r = {h, l};
  endtask : rd16
  task automatic ld(input int t, input qtc_byte_t l, input qtc_byte_t h);
    wr(ca(2 * t), l);
    wr(ca(2 * t + 1), h);
  endtask : ld
  task automatic setup(input qtc_byte_t m, input qtc_byte_t c);
    wr(`QTC_REG_RUN, 8'h00);
    wr(`QTC_REG_STATUS, 8'hff);
    wr(`QTC_REG_MODE, m);
    wr(`QTC_REG_CLK, c);
  endtask : setup
  task automatic fail(input string m);
    bad_count++;
    $display("MISMATCH %0t %s", $time, m);
  endtask : fail
  task automatic chk_byte(input qtc_byte_t g, input qtc_byte_t e, input string m);
    compares++;
    if (g !== e) fail(m);
  endtask : chk_byte
  task automatic chk_bit(input logic g, input logic e, input string m);
    compares++;
    if (g !== e) fail(m);
  endtask : chk_bit
  task automatic chk_range(input logic [15:0] g, input int lo, input int hi,
                           input string m);
    logic ok;
    compares++;
    ok = (g >= 16'(lo)) && (g <= 16'(hi));
    if (ok !== 1'b1) fail(m);
  endtask : chk_range
  task automatic wait_ovf(input int i, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      #1 n++;
    end while (n < lim && timer_ovf[i] !== 1'b1);
    chk_bit(timer_ovf[i], 1'b1, "overflow pulse missing");
  endtask : wait_ovf
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    wr(5'h1f, 8'hff);
    for (int a = 0; a < 5; a++) begin
      rd(5'(a), rv);
      chk_byte(rv, 8'h00, "reset value");
    end
    rd(5'h1f, rv);
    chk_byte(rv, 8'h00, "unmapped read");
  endtask : t_reset
  task automatic t_count;
    setup(8'h11, 8'h00);
    ld(0, 8'h00, 8'h00);
    wr(`QTC_REG_RUN, 8'h01);
    qtc_pin_src_i.events(0, 5, 2);
    repeat (8) @(posedge clock);
    rd(ca(0), rv);
    chk_byte(rv, 8'h05, "timer a event count");
    setup(8'h24, 8'h00);
    ld(1, 8'h00, 8'h00);
    wr(`QTC_REG_RUN, 8'h02);
    qtc_pin_src_i.events(1, 3, 3);
    repeat (8) @(posedge clock);
    rd(ca(2), rv);
    chk_byte(rv, 8'h03, "timer b event count");
  endtask : t_count
  task automatic t_prescale;
    for (int s = 0; s < 5; s++) begin
      setup(8'h01, (s == 4) ? 8'h04 : 8'(s));
      ld(0, 8'h00, 8'h00);
      wr(`QTC_REG_RUN, 8'h01);
      if (s == 3) qtc_pin_src_i.osc(40);
      else repeat (480) @(posedge clock);
      wr(`QTC_REG_RUN, 8'h00);
      rd16(0, v);
      if (s < 3) chk_range(v, 480 / dv[s] - 1, 480 / dv[s] + 2, "prescale");
      else if (s == 3) chk_range(v, 4, 6, "oscillator over 8");
      else chk_range(v, 480, 484, "fast clock");
    end
  endtask : t_prescale
  task automatic t_gate;
    setup(8'h41, 8'h04);
    ld(0, 8'h00, 8'h00);
    wr(`QTC_REG_RUN, 8'h01);
    repeat (20) @(posedge clock);
    rd(ca(0), rv);
    chk_byte(rv, 8'h00, "gated timer moved");
    qtc_pin_src_i.gate(1'b1, 1'b0);
    repeat (20) @(posedge clock);
    wr(`QTC_REG_RUN, 8'h00);
    rd16(0, v);
    chk_range(v, 12, 26, "gate open count");
    qtc_pin_src_i.gate(1'b0, 1'b0);
  endtask : t_gate
  task automatic t_mode13;
    setup(8'h00, 8'h04);
    ld(0, 8'h1c, 8'hff);
    wr(`QTC_REG_MASK, 8'h01);
    wr(`QTC_REG_RUN, 8'h01);
    wait_ovf(0, 20);
    wr(`QTC_REG_RUN, 8'h00);
    chk_bit(irq, 1'b1, "irq after overflow");
    rd(ca(1), rv);
    chk_byte(rv, 8'h00, "13-bit wrap high byte");
    rd(`QTC_REG_STATUS, rv);
    chk_byte(rv, 8'h01, "status a");
    wr(`QTC_REG_STATUS, 8'h01);
    #1 chk_bit(irq, 1'b0, "irq after clear");
  endtask : t_mode13
  task automatic t_reload8;
    setup(8'h02, 8'h04);
    wr(`QTC_REG_MASK, 8'h00);
    ld(0, 8'hfc, 8'hf0);
    wr(`QTC_REG_RUN, 8'h01);
    wait_ovf(0, 20);
    wr(`QTC_REG_RUN, 8'h00);
    chk_bit(irq, 1'b0, "masked irq");
    rd16(0, v);
    chk_byte(v[15:8], 8'hf0, "reload byte changed");
    chk_range(v, 16'hf0f0, 16'hf0f8, "reloaded low byte");
    rd(`QTC_REG_STATUS, rv);
    chk_byte(rv, 8'h01, "status after reload");
  endtask : t_reload8
  task automatic t_split;
    setup(8'h03, 8'h04);
    ld(0, 8'h00, 8'hfc);
    wr(`QTC_REG_RUN, 8'h03);
    wait_ovf(1, 20);
    wr(`QTC_REG_RUN, 8'h00);
    rd(`QTC_REG_STATUS, rv);
    chk_byte(rv, 8'h02, "split high flag");
  endtask : t_split
  task automatic t_timer_c;
    setup(8'h00, 8'h10);
    ld(2, 8'hf0, 8'hff);
    wr(`QTC_REG_RLD0, 8'h34);
    wr(`QTC_REG_RLD0 + 5'h1, 8'h12);
    wr(`QTC_REG_MASK, 8'h04);
    wr(`QTC_REG_RUN, 8'h04);
    wait_ovf(2, 40);
    wr(`QTC_REG_RUN, 8'h00);
    chk_bit(irq, 1'b1, "irq timer c");
    rd16(2, v);
    chk_range(v, 16'h1234, 16'h1240, "timer c reload");
    wr(`QTC_REG_STATUS, 8'hff);
    #1 chk_bit(irq, 1'b0, "irq timer c clear");
  endtask : t_timer_c
  task automatic t_split_c;
    setup(8'h0c, 8'h00);
    ld(1, 8'h55, 8'h00);
    ld(2, 8'hfe, 8'hfd);
    wr(`QTC_REG_RUN, 8'h16);
    wait_ovf(2, 40);
    repeat (16) @(posedge clock);
    wr(`QTC_REG_RUN, 8'h00);
    rd(`QTC_REG_STATUS, rv);
    chk_byte(rv, 8'h0c, "split c flags");
    rd16(2, v);
    chk_range(v, 16'h1235, 16'h1336, "split c halves reload");
    rd(ca(2), rv);
    chk_byte(rv, 8'h55, "timer b held in split");
  endtask : t_split_c
  task automatic t_timer_d;
    setup(8'h00, 8'h80);
    ld(3, 8'hff, 8'hff);
    wr(`QTC_REG_RUN, 8'h08);
    @(posedge clock);
    suspend <= 1'b1;
    fork
      qtc_pin_src_i.osc(16);
      wait_ovf(3, 80);
    join
    chk_bit(wake_request, 1'b1, "wake in suspend");
    rd(`QTC_REG_STATUS, rv);
    chk_byte(rv, 8'h50, "status timer d");
    wr(`QTC_REG_STATUS, 8'hff);
    suspend <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk_bit(wake_request, 1'b0, "wake cleared");
  endtask : t_timer_d
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_count();
    t_prescale();
    t_gate();
    t_mode13();
    t_reload8();
    t_split();
    t_timer_c();
    t_split_c();
    t_timer_d();
    stop_test();
  end
endmodule : test_qtc_top
